// ---- src/dsd_host.sv ----
// Host controller that loads words into both channels of a dual serial DAC.
`include "dsd_defs.svh"

module dsd_host (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic req_valid_i,
  input wire dsd_pkg::dsd_req_type req_i,
  output logic req_ready_o,
  output logic done_o,
  output logic chan_a_shift_clock_o,
  output logic chan_b_shift_clock_o,
  output logic chan_a_serial_in_o,
  output logic chan_b_serial_in_o,
  output logic chan_a_frame_n_o,
  output logic chan_b_frame_n_o,
  output logic chan_a_load_strobe_n_o,
  output logic chan_b_load_strobe_n_o
);
  import dsd_pkg::*;

  localparam logic [`DSD_TMR_BITS-1:0] STROBE_LAST = `DSD_TMR_BITS'(`DSD_STROBE_CYC - 1);
  localparam logic [`DSD_TMR_BITS-1:0] GAP_LAST = `DSD_TMR_BITS'(`DSD_BYTE_GAP_CYC - 1);

  function automatic logic [15:0] dsd_pack_word(input dsd_req_type r);
    logic [15:0] w;
    w = {2'h0, r.code};
    if (r.res12) begin
      w = {4'h0, r.code[`DSD_CODE12_MSB:0]};
    end
    return w;
  endfunction

  dsd_state_type state, next_state;
  dsd_strobe_mode_type mode_q, next_mode_q;
  logic ph, next_ph;
  logic [4:0] bit_cnt, next_bit_cnt;
  logic [`DSD_TMR_BITS-1:0] tmr, next_tmr;
  logic [15:0] sr, next_sr;
  logic chan_q, next_chan_q;
  logic byte_q, next_byte_q;
  logic sclk, next_sclk;
  logic sdata, next_sdata;
  logic frame_a_n, next_frame_a_n;
  logic frame_b_n, next_frame_b_n;
  logic strb_a_n, next_strb_a_n;
  logic strb_b_n, next_strb_b_n;
  logic ready, next_ready;
  logic done, next_done;

  wire accept = (state == ST_IDLE) && req_valid_i && ready;
  wire [15:0] req_word = dsd_pack_word(req_i);
  wire last_fall = (bit_cnt == `DSD_LAST_BIT_IDX);
  wire byte_fall = byte_q && (bit_cnt == `DSD_LAST_BYTE_BIT_IDX);
  wire pulse_mode = (mode_q != STRB_TIED);
  wire strobe_a_sel = (mode_q == STRB_COMMON) || !chan_q;
  wire strobe_b_sel = (mode_q == STRB_COMMON) || chan_q;
  wire tied_req = (req_i.strobe_mode == STRB_TIED);

  always_comb begin
    next_state = state;
    next_mode_q = mode_q;
    next_ph = ph;
    next_bit_cnt = bit_cnt;
    next_tmr = tmr;
    next_sr = sr;
    next_chan_q = chan_q;
    next_byte_q = byte_q;
    next_sclk = sclk;
    next_sdata = sdata;
    next_frame_a_n = frame_a_n;
    next_frame_b_n = frame_b_n;
    next_strb_a_n = strb_a_n;
    next_strb_b_n = strb_b_n;
    next_ready = ready;
    next_done = 1'b0;
    case (state)
      ST_IDLE: begin
        if (accept) begin
          next_state = ST_SHIFT;
          next_ready = 1'b0;
          next_sr = req_word;
          next_sdata = req_word[15];
          next_sclk = 1'b0;
          next_ph = 1'b0;
          next_bit_cnt = 5'h00;
          next_chan_q = req_i.channel_select;
          next_byte_q = req_i.byte_mode;
          next_mode_q = req_i.strobe_mode;
          next_frame_a_n = req_i.channel_select;
          next_frame_b_n = !req_i.channel_select;
          next_strb_a_n = !tied_req;
          next_strb_b_n = !tied_req;
        end
      end
      ST_SHIFT: begin
        if (!ph) begin
          next_sclk = 1'b1;
          next_ph = 1'b1;
          if (bit_cnt != 5'h00) begin
            next_sdata = sr[15];
          end
        end else begin
          next_sclk = 1'b0;
          next_ph = 1'b0;
          next_sr = {sr[14:0], 1'b0};
          next_bit_cnt = bit_cnt + 5'h01;
          if (last_fall) begin
            next_state = ST_END;
          end else if (byte_fall) begin
            next_state = ST_GAP;
            next_tmr = GAP_LAST;
          end
        end
      end
      ST_GAP: begin
        next_tmr = tmr - `DSD_TMR_BITS'(1);
        if (tmr == '0) begin
          next_state = ST_SHIFT;
        end
      end
      ST_END: begin
        next_frame_a_n = 1'b1;
        next_frame_b_n = 1'b1;
        if (pulse_mode) begin
          next_state = ST_STROBE;
          next_tmr = STROBE_LAST;
          next_strb_a_n = !strobe_a_sel;
          next_strb_b_n = !strobe_b_sel;
        end else begin
          next_state = ST_IDLE;
          next_ready = 1'b1;
          next_done = 1'b1;
        end
      end
      ST_STROBE: begin
        next_tmr = tmr - `DSD_TMR_BITS'(1);
        if (tmr == '0) begin
          next_state = ST_IDLE;
          next_strb_a_n = 1'b1;
          next_strb_b_n = 1'b1;
          next_ready = 1'b1;
          next_done = 1'b1;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= ST_IDLE;
      mode_q <= STRB_CHAN;
      ph <= 1'b0;
      bit_cnt <= 5'h00;
      tmr <= '0;
      sr <= 16'h0000;
      chan_q <= 1'b0;
      byte_q <= 1'b0;
      sclk <= 1'b0;
      sdata <= 1'b0;
      frame_a_n <= 1'b1;
      frame_b_n <= 1'b1;
      strb_a_n <= 1'b1;
      strb_b_n <= 1'b1;
      ready <= 1'b1;
      done <= 1'b0;
    end else begin
      state <= next_state;
      mode_q <= next_mode_q;
      ph <= next_ph;
      bit_cnt <= next_bit_cnt;
      tmr <= next_tmr;
      sr <= next_sr;
      chan_q <= next_chan_q;
      byte_q <= next_byte_q;
      sclk <= next_sclk;
      sdata <= next_sdata;
      frame_a_n <= next_frame_a_n;
      frame_b_n <= next_frame_b_n;
      strb_a_n <= next_strb_a_n;
      strb_b_n <= next_strb_b_n;
      ready <= next_ready;
      done <= next_done;
    end
  end

  // Both ports share one clock and data source; the frames pick the channel.
  assign chan_a_shift_clock_o = sclk;
  assign chan_b_shift_clock_o = sclk;
  assign chan_a_serial_in_o = sdata;
  assign chan_b_serial_in_o = sdata;
  assign chan_a_frame_n_o = frame_a_n;
  assign chan_b_frame_n_o = frame_b_n;
  assign chan_a_load_strobe_n_o = strb_a_n;
  assign chan_b_load_strobe_n_o = strb_b_n;
  assign req_ready_o = ready;
  assign done_o = done;

  // Helper logic that only the checks read.
  logic sclk_d;
  logic [4:0] fall_cnt;
  logic [15:0] acc_word;
  wire any_frame = !frame_a_n || !frame_b_n;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sclk_d <= 1'b0;
      fall_cnt <= 5'h00;
      acc_word <= 16'h0000;
    end else begin
      sclk_d <= sclk;
      if (accept) begin
        acc_word <= req_word;
      end
      if (!any_frame) begin
        fall_cnt <= 5'h00;
      end else if (sclk_d && !sclk) begin
        fall_cnt <= fall_cnt + 5'h01;
      end
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence strobe_low_two;
    !strb_a_n [*2];
  endsequence

  sequence strobe_back_high;
    strb_a_n && frame_a_n && frame_b_n;
  endsequence

  chk_frame_one_hot: assert property (!(!frame_a_n && !frame_b_n))
    else $error("Both frames asserted at once.");

  chk_data_at_fall: assert property ($fell(sclk) |-> $stable(sdata))
    else $error("Serial data changed on a falling clock edge.");

  chk_sixteen_falls: assert property ($rose(any_frame == 1'b0) |-> fall_cnt == 5'd16)
    else $error("Frame did not carry exactly sixteen falling edges.");

  chk_first_bit: assert property ($fell(frame_a_n) || $fell(frame_b_n)
      |-> !sclk && sdata == acc_word[15])
    else $error("First bit not ready when frame fell.");

  chk_lsb_last: assert property ($rose(frame_a_n) || $rose(frame_b_n)
      |-> sdata == acc_word[0])
    else $error("Last bit sent was not the least significant bit.");

  chk_tied_low: assert property (mode_q == STRB_TIED && state != ST_IDLE
      |-> !strb_a_n && !strb_b_n)
    else $error("Strobes not held low in tied mode.");

  chk_strobe_after_frame: assert property ($fell(strb_a_n) && mode_q != STRB_TIED
      |-> frame_a_n && frame_b_n ##0 strobe_low_two ##1 strobe_back_high)
    else $error("Load strobe pulse overlapped a load or had the wrong width.");

  chk_gap_frame_low: assert property (state == ST_GAP |-> any_frame && !sclk)
    else $error("Frame released between the two bytes.");

  sequence gap_four_cycles;
    (state == ST_GAP) [*4];
  endsequence

  chk_byte_gap_length: assert property ($rose(state == ST_GAP)
      |-> gap_four_cycles ##1 state == ST_SHIFT && any_frame)
    else $error("Pause between the two bytes had the wrong length.");

  chk_chan_strobe_only: assert property (state == ST_STROBE && mode_q == STRB_CHAN
      |-> strb_a_n == chan_q && strb_b_n == !chan_q)
    else $error("Channel strobe pulse reached the wrong channel.");

  chk_common_strobe: assert property ($fell(strb_a_n) && mode_q == STRB_COMMON
      |-> $fell(strb_b_n))
    else $error("Common strobe did not reach both channels.");

  chk_ready_busy: assert property (any_frame |-> !req_ready_o && !done_o)
    else $error("Controller ready or done while a frame is open.");

endmodule

// ---- src/dsd_defs.svh ----
// Timing and field constants for the dual serial DAC load port controller.
`ifndef DSD_DEFS_SVH
`define DSD_DEFS_SVH

`define DSD_CLK_PERIOD_NS 100
`define DSD_WORD_BITS 16
`define DSD_BYTE_BITS 8
`define DSD_LAST_BIT_IDX 5'h0f
`define DSD_LAST_BYTE_BIT_IDX 5'h07
`define DSD_CODE_MSB 13
`define DSD_CODE12_MSB 11
`define DSD_STROBE_LOW_NS 200
`define DSD_STROBE_CYC ((`DSD_STROBE_LOW_NS + `DSD_CLK_PERIOD_NS - 1) / `DSD_CLK_PERIOD_NS)
`define DSD_BYTE_GAP_NS 400
`define DSD_BYTE_GAP_CYC ((`DSD_BYTE_GAP_NS + `DSD_CLK_PERIOD_NS - 1) / `DSD_CLK_PERIOD_NS)
`define DSD_TMR_BITS 3

`endif

// ---- src/dsd_pkg.sv ----
// Types shared by the dual serial DAC load port controller.
package dsd_pkg;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SHIFT  = 3'b001,
    ST_GAP    = 3'b010,
    ST_END    = 3'b011,
    ST_STROBE = 3'b100
  } dsd_state_type;

  typedef enum logic [1:0] {
    STRB_TIED   = 2'b00,
    STRB_CHAN   = 2'b01,
    STRB_COMMON = 2'b10
  } dsd_strobe_mode_type;

  typedef struct packed {
    logic channel_select;
    logic res12;
    logic byte_mode;
    dsd_strobe_mode_type strobe_mode;
    logic [13:0] code;
  } dsd_req_type;

endpackage

// ---- bench/dsd_dac_model.sv ----
// Behavioural model of one converter channel's serial load port and latches.
module dsd_dac_model (
  input wire logic shift_clock_i,
  input wire logic serial_in_i,
  input wire logic frame_n_i,
  input wire logic load_strobe_n_i,
  output logic [15:0] dac_latch_o,
  output int updates_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] in_latch;
  int bit_cnt;
  initial begin
    in_latch = 16'h0000;
    dac_latch_o = 16'h0000;
    bit_cnt = 16;
    updates_o = 0;
  end
  always @(negedge frame_n_i) bit_cnt = 0;
  always @(negedge shift_clock_i) begin
    if (!frame_n_i && bit_cnt < 16) begin
      in_latch = {in_latch[14:0], serial_in_i};
      bit_cnt++;
      if (bit_cnt == 16 && !load_strobe_n_i) begin
        dac_latch_o = in_latch;
        updates_o++;
      end
    end
  end
  always @(negedge load_strobe_n_i) begin
    #1;
    if (frame_n_i || bit_cnt == 16) begin
      dac_latch_o = in_latch;
      updates_o++;
    end
  end
endmodule

// ---- bench/dual_serial_dac_load_port_tb.sv ----
// Self-checking bench for the dual serial DAC load port controller.
module dual_serial_dac_load_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dsd_pkg::*;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic req_valid_i = 1'b0;
  dsd_req_type req_i = '0;
  logic req_ready_o, done_o, sck_a, sck_b, sd_a, sd_b, fr_a, fr_b, st_a, st_b;
  logic [15:0] lat_a, lat_b;
  int upd_a, upd_b;
  int errors = 0;
  int total_checks = 0;
  logic [15:0] lfsr = 16'h6b9d;
  logic [15:0] exp_lat [2];
  int exp_upd [2];
  logic strb_low = 1'b0;
  dsd_host DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .req_ready_o(req_ready_o), .done_o(done_o), .chan_a_shift_clock_o(sck_a),
    .chan_b_shift_clock_o(sck_b), .chan_a_serial_in_o(sd_a), .chan_b_serial_in_o(sd_b),
    .chan_a_frame_n_o(fr_a), .chan_b_frame_n_o(fr_b), .chan_a_load_strobe_n_o(st_a),
    .chan_b_load_strobe_n_o(st_b));
  dsd_dac_model dac_a (.shift_clock_i(sck_a), .serial_in_i(sd_a), .frame_n_i(fr_a),
    .load_strobe_n_i(st_a), .dac_latch_o(lat_a), .updates_o(upd_a));
  dsd_dac_model dac_b (.shift_clock_i(sck_b), .serial_in_i(sd_b), .frame_n_i(fr_b),
    .load_strobe_n_i(st_b), .dac_latch_o(lat_b), .updates_o(upd_b));
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    if (arst_n_i && (!fr_a && !fr_b || sck_a !== sck_b || sd_a !== sd_b)) begin
      errors++;
      $display("[ERR] shared lines expected one frame seen %b%b", fr_a, fr_b);
    end
  end
  task automatic send(input logic ch, input logic r12, input logic bm,
                      input dsd_strobe_mode_type sm, input logic [13:0] code);
    int n;
    req_i <= '{channel_select: ch, res12: r12, byte_mode: bm, strobe_mode: sm, code: code};
    req_valid_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (req_ready_o !== 1'b1 && n < 100);
    req_valid_i <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (done_o !== 1'b1 && n < 100);
    check("done", 32'h1, {31'h0, done_o});
    exp_lat[ch] = r12 ? {4'h0, code[11:0]} : {2'h0, code};
    exp_upd[ch]++;
    if (sm == STRB_COMMON) exp_upd[!ch]++;
    // A tied request lowers both strobes at once, which reloads the idle channel.
    if (sm == STRB_TIED && !strb_low) exp_upd[!ch]++;
    strb_low = (sm == STRB_TIED);
    check("latch_a", {16'h0, exp_lat[0]}, {16'h0, lat_a});
    check("latch_b", {16'h0, exp_lat[1]}, {16'h0, lat_b});
    check("updates_a", exp_upd[0], upd_a);
    check("updates_b", exp_upd[1], upd_b);
  endtask
  initial begin
    #200000;
    errors++;
    $display("[ERR] watchdog expected finish seen hang");
    conclude();
  end
  initial begin
    dsd_strobe_mode_type sm;
    exp_lat[0] = 16'h0000;
    exp_lat[1] = 16'h0000;
    exp_upd[0] = 0;
    exp_upd[1] = 0;
    lfsr = 16'h6b9d;
    repeat (5) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    for (int i = 0; i < 12; i++) begin
      lfsr = lfsr_next(lfsr);
      sm = dsd_strobe_mode_type'(i % 3);
      send(i[0], i[1], i[2], sm, lfsr[13:0]);
      $display("test %0d done", i);
    end
    conclude();
  end
endmodule
